// file: cmp_output_ctrl.sv
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/10ps
`default_nettype none

module cmp_output_ctrl (
  input  wire logic                                i_core_clk,
  input  wire logic                                i_arst_n,
  // Register port
  input  wire logic [cmp_ctrl_pkg::REG_ADDR_W-1:0] i_reg_addr,
  input  wire logic [cmp_ctrl_pkg::REG_DATA_W-1:0] i_reg_wdata,
  input  wire logic                                i_reg_wr,
  input  wire logic                                i_reg_rd,
  output logic      [cmp_ctrl_pkg::REG_DATA_W-1:0] o_reg_rdata,
  // Comparator digital results and pins
  input  wire logic                                i_cmp1_result,
  input  wire logic                                i_cmp2_result,
  input  wire logic                                i_external_gate_pin,
  // Timer1 side
  input  wire logic                                i_timer_clk_prescaled,
  input  wire logic                                i_timer_on,
  input  wire logic                                i_timer_gate_enable,
  output logic                                     o_timer_gate_level,
  output logic                                     o_timer_count_enable,
  output logic                                     o_synced_cmp2_result,
  // Port pin paths
  output logic                                     o_cmp1_pin_path,
  output logic                                     o_cmp2_pin_path,
  output logic                                     o_latch_state,
  // Reference control
  output logic                                     o_cmp1_ref_select,
  output logic                                     o_cmp2_ref_select,
  output logic                                     o_ladder_divider_enable,
  output logic                                     o_fixed_ref_enable
);

  import cmp_ctrl_pkg::*;

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic reg_hit(
    input logic [REG_ADDR_W-1:0] addr,
    input logic [REG_ADDR_W-1:0] offset
  );
    reg_hit = (addr == offset);
  endfunction

  function automatic logic pick(
    input logic sel,
    input logic when_one,
    input logic when_zero
  );
    pick = sel ? when_one : when_zero;
  endfunction

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  logic [3:0] async_in;
  logic [3:0] synced;
  logic       cmp1_s;
  logic       cmp2_s;
  logic       gate_pin_s;
  logic       tclk_s;
  logic       tclk_prev_q;
  logic       tclk_fall;

  logic       cmp1_ref_select_q;
  logic       cmp2_ref_select_q;
  logic       timer_gate_source_select_q;
  logic       cmp2_sync_enable_q;

  logic       latch_route_hi_q;
  logic       latch_route_lo_q;
  logic       cmp1_set_gate_q;
  logic       cmp2_reset_gate_q;
  logic       fixed_ref_enable_q;
  logic       sw_set_pulse_q;
  logic       sw_reset_pulse_q;

  logic       wr_aux;
  logic       wr_latch;
  logic       cmp2_captured_q;
  logic       cmp2_gate_src;
  logic       latch_q;
  logic       latch_set;
  logic       latch_reset;
  logic       gate_level_d;
  logic       count_enable_d;
  logic [REG_DATA_W-1:0] rdata_d;

  // ------------------------------------------------------------------
  // Input synchronisation
  // ------------------------------------------------------------------
  // The prescaled timer clock is sampled as a level; its edges are slow
  // next to the core clock, so a sampled falling edge is good enough.
  assign async_in = {i_timer_clk_prescaled, i_external_gate_pin,
                     i_cmp2_result, i_cmp1_result};

  cmp_pin_sync #(
    .WIDTH (4)
  ) u_pin_sync (
    .i_core_clk (i_core_clk),
    .i_arst_n   (i_arst_n),
    .i_async    (async_in),
    .o_sync     (synced)
  );

  assign cmp1_s     = synced[0];
  assign cmp2_s     = synced[1];
  assign gate_pin_s = synced[2];
  assign tclk_s     = synced[3];

  // ------------------------------------------------------------------
  // Register write decode
  // ------------------------------------------------------------------
  always_comb begin
    wr_aux   = 1'b0;
    wr_latch = 1'b0;
    if (i_reg_wr && reg_hit(i_reg_addr, AUX_CTRL_OFFSET)) begin
      wr_aux = 1'b1;
    end else if (i_reg_wr && reg_hit(i_reg_addr, LATCH_CTRL_OFFSET)) begin
      wr_latch = 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // comparator_aux_control storage
  // ------------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cmp1_ref_select_q          <= AUX_CTRL_RESET[AUX_CMP1_REF_BIT];
      cmp2_ref_select_q          <= AUX_CTRL_RESET[AUX_CMP2_REF_BIT];
      timer_gate_source_select_q <= AUX_CTRL_RESET[AUX_GATE_SRC_BIT];
      cmp2_sync_enable_q         <= AUX_CTRL_RESET[AUX_CMP2_SYNC_BIT];
    end else if (wr_aux) begin
      cmp1_ref_select_q          <= i_reg_wdata[AUX_CMP1_REF_BIT];
      cmp2_ref_select_q          <= i_reg_wdata[AUX_CMP2_REF_BIT];
      timer_gate_source_select_q <= i_reg_wdata[AUX_GATE_SRC_BIT];
      cmp2_sync_enable_q         <= i_reg_wdata[AUX_CMP2_SYNC_BIT];
    end
  end

  // ------------------------------------------------------------------
  // latch_control storage
  // ------------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      latch_route_hi_q   <= LATCH_CTRL_RESET[LATCH_ROUTE_HI_BIT];
      latch_route_lo_q   <= LATCH_CTRL_RESET[LATCH_ROUTE_LO_BIT];
      cmp1_set_gate_q    <= LATCH_CTRL_RESET[LATCH_SET_GATE_BIT];
      cmp2_reset_gate_q  <= LATCH_CTRL_RESET[LATCH_RESET_GATE_BIT];
      fixed_ref_enable_q <= LATCH_CTRL_RESET[LATCH_FIXED_REF_BIT];
    end else if (wr_latch) begin
      latch_route_hi_q   <= i_reg_wdata[LATCH_ROUTE_HI_BIT];
      latch_route_lo_q   <= i_reg_wdata[LATCH_ROUTE_LO_BIT];
      cmp1_set_gate_q    <= i_reg_wdata[LATCH_SET_GATE_BIT];
      cmp2_reset_gate_q  <= i_reg_wdata[LATCH_RESET_GATE_BIT];
      fixed_ref_enable_q <= i_reg_wdata[LATCH_FIXED_REF_BIT];
    end
  end

  // ------------------------------------------------------------------
  // Software pulse generators
  // ------------------------------------------------------------------
  // Pulse flops hold only for the cycle after the write, so there is
  // nothing to clear and a zero write simply leaves them low.
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sw_set_pulse_q   <= 1'b0;
      sw_reset_pulse_q <= 1'b0;
    end else begin
      sw_set_pulse_q   <= wr_latch & i_reg_wdata[LATCH_SET_PULSE_BIT];
      sw_reset_pulse_q <= wr_latch & i_reg_wdata[LATCH_RST_PULSE_BIT];
    end
  end

  // ------------------------------------------------------------------
  // Comparator two capture on the timer clock
  // ------------------------------------------------------------------
  // The timer counts on the rising edge, so capturing on the falling
  // edge keeps the gate stable across every increment.
  assign tclk_fall = tclk_prev_q & ~tclk_s;

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tclk_prev_q <= 1'b0;
    end else begin
      tclk_prev_q <= tclk_s;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cmp2_captured_q <= 1'b0;
    end else if (tclk_fall) begin
      cmp2_captured_q <= cmp2_s;
    end
  end

  assign cmp2_gate_src = pick(cmp2_sync_enable_q, cmp2_captured_q, cmp2_s);

  // ------------------------------------------------------------------
  // Timer gate selection
  // ------------------------------------------------------------------
  always_comb begin
    gate_level_d   = pick(timer_gate_source_select_q, gate_pin_s, cmp2_gate_src);
    count_enable_d = i_timer_on & (~i_timer_gate_enable | gate_level_d);
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_timer_gate_level   <= 1'b0;
      o_timer_count_enable <= 1'b0;
    end else begin
      o_timer_gate_level   <= gate_level_d;
      o_timer_count_enable <= count_enable_d;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_synced_cmp2_result <= 1'b0;
    end else begin
      o_synced_cmp2_result <= cmp2_gate_src;
    end
  end

  // ------------------------------------------------------------------
  // Set/reset latch
  // ------------------------------------------------------------------
  // Sampled every core cycle rather than built as a true async latch,
  // which costs one cycle of delay but stays timing-clean.
  assign latch_set   = (cmp1_set_gate_q & cmp1_s) | sw_set_pulse_q;
  assign latch_reset = (cmp2_reset_gate_q & cmp2_s) | sw_reset_pulse_q;

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      latch_q <= 1'b0;
    end else if (latch_reset) begin
      latch_q <= 1'b0;
    end else if (latch_set) begin
      latch_q <= 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // Output multiplexers toward the port logic
  // ------------------------------------------------------------------
  // No comparator enable takes part here; routing stands on its own.
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_cmp1_pin_path <= 1'b0;
      o_cmp2_pin_path <= 1'b0;
    end else begin
      o_cmp1_pin_path <= pick(latch_route_lo_q, latch_q, cmp1_s);
      o_cmp2_pin_path <= pick(latch_route_hi_q, ~latch_q, cmp2_s);
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_latch_state <= 1'b0;
    end else begin
      o_latch_state <= latch_q;
    end
  end

  // ------------------------------------------------------------------
  // Reference control outputs
  // ------------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_cmp1_ref_select       <= 1'b0;
      o_cmp2_ref_select       <= 1'b0;
      o_ladder_divider_enable <= 1'b0;
      o_fixed_ref_enable      <= 1'b0;
    end else begin
      o_cmp1_ref_select       <= cmp1_ref_select_q;
      o_cmp2_ref_select       <= cmp2_ref_select_q;
      o_ladder_divider_enable <= cmp1_ref_select_q | cmp2_ref_select_q;
      o_fixed_ref_enable      <= fixed_ref_enable_q;
    end
  end

  // ------------------------------------------------------------------
  // Register read
  // ------------------------------------------------------------------
  // Mirror bits come straight from the synchronised results and have no
  // read side effect, so status polling never disturbs change detection.
  always_comb begin
    rdata_d = UNMAPPED_READ_VALUE;
    if (reg_hit(i_reg_addr, AUX_CTRL_OFFSET)) begin
      rdata_d[AUX_MIRROR_CMP1_BIT] = cmp1_s;
      rdata_d[AUX_MIRROR_CMP2_BIT] = cmp2_s;
      rdata_d[AUX_CMP1_REF_BIT]    = cmp1_ref_select_q;
      rdata_d[AUX_CMP2_REF_BIT]    = cmp2_ref_select_q;
      rdata_d[AUX_GATE_SRC_BIT]    = timer_gate_source_select_q;
      rdata_d[AUX_CMP2_SYNC_BIT]   = cmp2_sync_enable_q;
    end else if (reg_hit(i_reg_addr, LATCH_CTRL_OFFSET)) begin
      rdata_d[LATCH_ROUTE_HI_BIT]   = latch_route_hi_q;
      rdata_d[LATCH_ROUTE_LO_BIT]   = latch_route_lo_q;
      rdata_d[LATCH_SET_GATE_BIT]   = cmp1_set_gate_q;
      rdata_d[LATCH_RESET_GATE_BIT] = cmp2_reset_gate_q;
      rdata_d[LATCH_FIXED_REF_BIT]  = fixed_ref_enable_q;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_reg_rdata <= '0;
    end else if (i_reg_rd) begin
      o_reg_rdata <= rdata_d;
    end else begin
      o_reg_rdata <= '0;
    end
  end

endmodule

`default_nettype wire

// file: cmp_ctrl_pkg.sv
`default_nettype none

package cmp_ctrl_pkg;

  // ------------------------------------------------------------------
  // Register bus geometry
  // ------------------------------------------------------------------
  localparam int unsigned REG_ADDR_W = 4;
  localparam int unsigned REG_DATA_W = 8;

  // ------------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------------
  localparam logic [REG_ADDR_W-1:0] AUX_CTRL_OFFSET   = 4'h0;
  localparam logic [REG_ADDR_W-1:0] LATCH_CTRL_OFFSET = 4'h1;

  // ------------------------------------------------------------------
  // comparator_aux_control fields
  // ------------------------------------------------------------------
  localparam int unsigned AUX_MIRROR_CMP1_BIT  = 7;
  localparam int unsigned AUX_MIRROR_CMP2_BIT  = 6;
  localparam int unsigned AUX_CMP1_REF_BIT     = 5;
  localparam int unsigned AUX_CMP2_REF_BIT     = 4;
  localparam int unsigned AUX_GATE_SRC_BIT     = 1;
  localparam int unsigned AUX_CMP2_SYNC_BIT    = 0;
  localparam logic [7:0]  AUX_CTRL_RESET       = 8'h02;

  // ------------------------------------------------------------------
  // latch_control fields
  // ------------------------------------------------------------------
  localparam int unsigned LATCH_ROUTE_HI_BIT   = 7;
  localparam int unsigned LATCH_ROUTE_LO_BIT   = 6;
  localparam int unsigned LATCH_SET_GATE_BIT   = 5;
  localparam int unsigned LATCH_RESET_GATE_BIT = 4;
  localparam int unsigned LATCH_SET_PULSE_BIT  = 3;
  localparam int unsigned LATCH_RST_PULSE_BIT  = 2;
  localparam int unsigned LATCH_FIXED_REF_BIT  = 0;
  localparam logic [7:0]  LATCH_CTRL_RESET     = 8'h00;

  // ------------------------------------------------------------------
  // Misc constants
  // ------------------------------------------------------------------
  localparam int unsigned SYNC_STAGES          = 2;
  localparam logic [7:0]  UNMAPPED_READ_VALUE  = 8'h00;

endpackage

`default_nettype wire

// file: cmp_pin_sync.sv
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------------------------
// Two-flop synchroniser for asynchronous levels
// ------------------------------------------------------------------
module cmp_pin_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             i_core_clk,
  input  wire logic             i_arst_n,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  // First stage feeds only the second stage, to keep metastability contained
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta_q <= '0;
      o_sync <= '0;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end

endmodule

`default_nettype wire

// file: cmp_output_ctrl_sva.sv
`timescale 1ns/10ps
`default_nettype none

module cmp_output_ctrl_chk
  import cmp_ctrl_pkg::*;
(
  input wire logic                  i_core_clk,
  input wire logic                  i_arst_n,
  input wire logic [REG_ADDR_W-1:0] i_reg_addr,
  input wire logic [REG_DATA_W-1:0] i_reg_wdata,
  input wire logic                  i_reg_wr,
  input wire logic                  i_reg_rd,
  input wire logic [REG_DATA_W-1:0] o_reg_rdata,
  input wire logic                  i_timer_clk_prescaled,
  input wire logic                  i_timer_on,
  input wire logic                  i_timer_gate_enable,
  input wire logic                  o_timer_count_enable,
  input wire logic                  o_synced_cmp2_result,
  input wire logic                  o_cmp1_pin_path,
  input wire logic                  o_cmp2_pin_path,
  input wire logic                  o_latch_state,
  input wire logic                  o_cmp1_ref_select,
  input wire logic                  o_cmp2_ref_select,
  input wire logic                  o_ladder_divider_enable
);
  // ------------------------------------------------------------------
  // Shadow of the routing and sync bits
  // ------------------------------------------------------------------
  logic       lat_wr, aux_wr, lo_q, hi_q, sync_q, tclk_q;
  logic [3:0] tcnt_q;
  assign lat_wr = i_reg_wr && (i_reg_addr == LATCH_CTRL_OFFSET);
  assign aux_wr = i_reg_wr && (i_reg_addr == AUX_CTRL_OFFSET);
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) {hi_q, lo_q} <= 2'b00;
    else if (lat_wr) {hi_q, lo_q} <= i_reg_wdata[7:6];
  end
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) sync_q <= 1'b0;
    else if (aux_wr) sync_q <= i_reg_wdata[0];
  end
  // Quiet time of the timer clock; a comparator_aux_control write restarts it so a fresh sync
  // setting is never judged before the capture path has settled
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tclk_q <= 1'b0;
      tcnt_q <= 4'h0;
    end else begin
      tclk_q <= i_timer_clk_prescaled;
      if ((i_timer_clk_prescaled != tclk_q) || aux_wr) tcnt_q <= 4'h0;
      else if (tcnt_q != 4'hf) tcnt_q <= tcnt_q + 4'h1;
    end
  end

  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_arst_n);

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  a_rdata_idle: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 8'h00)
    else $error("read data not idle");
  a_pulse_reads_zero: assert property (($past(i_reg_rd) &&
    $past(i_reg_addr) == LATCH_CTRL_OFFSET) |-> o_reg_rdata[3:1] == 3'h0)
    else $error("pulse bits read back set");
  a_reset_wins: assert property (lat_wr && i_reg_wdata[2] |-> ##3 !o_latch_state)
    else $error("latch not reset by pulse");
  a_set_pulse: assert property (lat_wr && i_reg_wdata[4:2] == 3'b010
    |-> ##3 o_latch_state) else $error("latch not set by pulse");
  a_ladder_or: assert property (o_ladder_divider_enable ==
    (o_cmp1_ref_select | o_cmp2_ref_select)) else $error("ladder enable wrong");
  a_timer_off: assert property (!$past(i_timer_on) |-> !o_timer_count_enable)
    else $error("counting while timer off");
  a_gate_free: assert property ($past(i_timer_on) && !$past(i_timer_gate_enable)
    |-> o_timer_count_enable) else $error("ungated timer not counting");
  a_route_lo: assert property (lo_q && $past(lo_q) |-> o_cmp1_pin_path == o_latch_state)
    else $error("pin one not latch output");
  a_route_hi: assert property (hi_q && $past(hi_q) |-> o_cmp2_pin_path != o_latch_state)
    else $error("pin two not inverted latch");
  a_sync_hold: assert property (sync_q && tcnt_q > 4'h7 |-> $stable(o_synced_cmp2_result))
    else $error("synced result moved without timer edge");

  c_set_pulse: cover property (lat_wr && i_reg_wdata[3]);
  c_route: cover property (lo_q && o_latch_state);
  c_gated: cover property (o_timer_count_enable && i_timer_gate_enable);
endmodule

bind cmp_output_ctrl cmp_output_ctrl_chk chk_u (
  .i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_reg_addr(i_reg_addr),
  .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
  .o_reg_rdata(o_reg_rdata), .i_timer_clk_prescaled(i_timer_clk_prescaled),
  .i_timer_on(i_timer_on), .i_timer_gate_enable(i_timer_gate_enable),
  .o_timer_count_enable(o_timer_count_enable), .o_synced_cmp2_result(o_synced_cmp2_result),
  .o_cmp1_pin_path(o_cmp1_pin_path), .o_cmp2_pin_path(o_cmp2_pin_path),
  .o_latch_state(o_latch_state), .o_cmp1_ref_select(o_cmp1_ref_select),
  .o_cmp2_ref_select(o_cmp2_ref_select), .o_ladder_divider_enable(o_ladder_divider_enable)
);

`default_nettype wire

// file: cmp_timer_model.sv
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------------------------
// Timer model: prescaled clock and gated counter
// ------------------------------------------------------------------
module cmp_timer_model (
  input  wire logic        i_core_clk,
  input  wire logic        i_arst_n,
  input  wire logic        i_run,
  input  wire logic [3:0]  i_half,
  input  wire logic        i_count_enable,
  output logic             o_tclk,
  output logic [15:0]      o_count
);
  logic [3:0] div_q;
  // Clock stands low while stopped; counting in the core domain avoids
  // a race between the gate and the timer clock edge
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      div_q   <= 4'h0;
      o_tclk  <= 1'b0;
      o_count <= 16'h0000;
    end else if (!i_run) begin
      div_q  <= 4'h0;
      o_tclk <= 1'b0;
    end else if (div_q == i_half) begin
      div_q  <= 4'h0;
      o_tclk <= !o_tclk;
      if (!o_tclk && i_count_enable) o_count <= o_count + 16'h0001;
    end else begin
      div_q <= div_q + 4'h1;
    end
  end
endmodule

`default_nettype wire

// file: cmp_output_ctrl_tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module cmp_output_ctrl_tb_top;
  import cmp_ctrl_pkg::*;
  logic        clk = 1'b0, arst_n = 1'b0, wr = 1'b0, rd = 1'b0;
  logic        cmp1 = 1'b0, cmp2 = 1'b0, gpin = 1'b0;
  logic        t_on = 1'b0, g_en = 1'b0, run = 1'b0;
  logic [3:0]  addr = 4'h0, half = 4'h3;
  logic [7:0]  wdata = 8'h00, rdata;
  logic        tclk, gate_lvl, cnt_en, sync2, pin1, pin2, lat, ref1, ref2, ladder, fref;
  logic [15:0] tcount, c0;
  int          n_errors = 0;
  int          compares = 0;

  always #5 clk = ~clk;

  cmp_output_ctrl dut_u (
    .i_core_clk(clk), .i_arst_n(arst_n), .i_reg_addr(addr), .i_reg_wdata(wdata),
    .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .i_cmp1_result(cmp1),
    .i_cmp2_result(cmp2), .i_external_gate_pin(gpin), .i_timer_clk_prescaled(tclk),
    .i_timer_on(t_on), .i_timer_gate_enable(g_en), .o_timer_gate_level(gate_lvl),
    .o_timer_count_enable(cnt_en), .o_synced_cmp2_result(sync2), .o_cmp1_pin_path(pin1),
    .o_cmp2_pin_path(pin2), .o_latch_state(lat), .o_cmp1_ref_select(ref1),
    .o_cmp2_ref_select(ref2), .o_ladder_divider_enable(ladder), .o_fixed_ref_enable(fref)
  );
  cmp_timer_model tmr_u (
    .i_core_clk(clk), .i_arst_n(arst_n), .i_run(run), .i_half(half),
    .i_count_enable(cnt_en), .o_tclk(tclk), .o_count(tcount)
  );

  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  task automatic check(input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    wait_cyc(6);
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 check(rdata, e);
  endtask
  task automatic set_in(input logic a, input logic b, input logic g);
    @(posedge clk);
    cmp1 <= a;
    cmp2 <= b;
    gpin <= g;
    wait_cyc(8);
  endtask
  task automatic set_tmr(input logic on, input logic ge, input logic rn);
    @(posedge clk);
    t_on <= on;
    g_en <= ge;
    run  <= rn;
    wait_cyc(8);
  endtask
  task automatic final_report;
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Whole sequence takes about 500 cycles; forty times that is a hang
  initial begin
    #200us;
    n_errors++;
    final_report();
  end

  initial begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    rd_chk(AUX_CTRL_OFFSET, 8'h02);
    rd_chk(LATCH_CTRL_OFFSET, 8'h00);
    reg_wr(4'h7, 8'hff);
    rd_chk(4'h7, 8'h00);
    rd_chk(AUX_CTRL_OFFSET, 8'h02);
    check({6'h0, pin2, pin1}, 8'h00);
    $display("test reset done");
    reg_wr(AUX_CTRL_OFFSET, 8'hff);
    rd_chk(AUX_CTRL_OFFSET, 8'h33);
    check({5'h0, ladder, ref2, ref1}, 8'h07);
    reg_wr(AUX_CTRL_OFFSET, 8'h10);
    check({5'h0, ladder, ref2, ref1}, 8'h06);
    set_in(1'b1, 1'b0, 1'b0);
    rd_chk(AUX_CTRL_OFFSET, 8'h90);
    set_in(1'b0, 1'b1, 1'b0);
    rd_chk(AUX_CTRL_OFFSET, 8'h50);
    rd_chk(AUX_CTRL_OFFSET, 8'h50);
    $display("test mirror done");
    reg_wr(LATCH_CTRL_OFFSET, 8'h08);
    check({7'h0, lat}, 8'h01);
    rd_chk(LATCH_CTRL_OFFSET, 8'h00);
    reg_wr(LATCH_CTRL_OFFSET, 8'h0d);
    check({6'h0, fref, lat}, 8'h02);
    rd_chk(LATCH_CTRL_OFFSET, 8'h01);
    reg_wr(LATCH_CTRL_OFFSET, 8'h30);
    set_in(1'b1, 1'b0, 1'b0);
    check({7'h0, lat}, 8'h01);
    set_in(1'b1, 1'b1, 1'b0);
    check({7'h0, lat}, 8'h00);
    reg_wr(LATCH_CTRL_OFFSET, 8'h00);
    set_in(1'b1, 1'b0, 1'b0);
    check({7'h0, lat}, 8'h00);
    reg_wr(LATCH_CTRL_OFFSET, 8'h08);
    set_in(1'b0, 1'b1, 1'b0);
    check({7'h0, lat}, 8'h01);
    $display("test latch done");
    reg_wr(LATCH_CTRL_OFFSET, 8'hc0);
    check({6'h0, pin2, pin1}, 8'h01);
    rd_chk(AUX_CTRL_OFFSET, 8'h50);
    reg_wr(LATCH_CTRL_OFFSET, 8'h00);
    check({6'h0, pin2, pin1}, 8'h02);
    $display("test routing done");
    reg_wr(AUX_CTRL_OFFSET, 8'h02);
    set_tmr(1'b1, 1'b1, 1'b1);
    set_in(1'b0, 1'b1, 1'b1);
    check({7'h0, gate_lvl}, 8'h01);
    c0 = tcount;
    wait_cyc(60);
    check({7'h0, tcount != c0}, 8'h01);
    set_in(1'b0, 1'b1, 1'b0);
    check({7'h0, gate_lvl}, 8'h00);
    c0 = tcount;
    wait_cyc(60);
    check({7'h0, tcount != c0}, 8'h00);
    // Software duty: sync on whenever comparator two gates the timer
    reg_wr(AUX_CTRL_OFFSET, 8'h01);
    half <= 4'h1;
    c0 = tcount;
    wait_cyc(60);
    check({6'h0, sync2, tcount != c0}, 8'h03);
    check({7'h0, gate_lvl}, 8'h01);
    set_tmr(1'b1, 1'b1, 1'b0);
    set_in(1'b0, 1'b0, 1'b0);
    check({7'h0, sync2}, 8'h01);
    set_tmr(1'b1, 1'b1, 1'b1);
    c0 = tcount;
    wait_cyc(60);
    check({6'h0, sync2, tcount != c0}, 8'h00);
    reg_wr(AUX_CTRL_OFFSET, 8'h00);
    set_tmr(1'b1, 1'b1, 1'b0);
    set_in(1'b0, 1'b1, 1'b0);
    check({7'h0, sync2}, 8'h01);
    set_tmr(1'b0, 1'b0, 1'b0);
    check({7'h0, cnt_en}, 8'h00);
    set_tmr(1'b1, 1'b0, 1'b0);
    check({7'h0, cnt_en}, 8'h01);
    $display("test timer done");
    final_report();
  end
endmodule

`default_nettype wire
